/* File: rtl/csrf_regfile.sv */
// Control and status register file of one hardware thread
//
// Notes on behaviour
// - Supervisor trap setup registers answer at 0x100 and 0x102 to 0x106.
// - Supervisor trap handling registers answer at 0x140 to 0x144.
// - Translation control sits at 0x180, read-write from supervisor level.
// - Machine trap setup registers answer at 0x300 to 0x306.
// - Machine trap handling registers answer at 0x340 to 0x344.
// - Protection config at 0x3A0 to 0x3A3; odd ones exist for 32-bit base.
// - Sixteen protection address registers at 0x3B0 to 0x3BF.
// - Writable cycle, retired and perf counters; upper halves from 0xB80.
// - Event selectors at 0x323 to 0x33F, one per counter 3 to 31.
// - Trigger select and three trigger data registers at 0x7A0 to 0x7A3.
// - Debug control, debug PC and debug scratch usable only in debug mode.
// - Writes to ignore-on-read reserved bits are dropped; they read zero.
// - Writes to a wholly read-only register raise illegal instruction.
// - Legal-only fields keep few bits but read back the full encoding.
// - Unsupported writes to legal-only fields may raise illegal; here none.
// - Illegal legal-only writes read back a fixed function of the value.
// - Write-any fields take every write and always read a legal code.
// - Write-any fields never cause an exception.
// - Each illegal write-any value maps to the same legal value, except a paging write to translation control, which keeps the old value.
// - Number bits 11:10 both set mean read-only; bits 9:8 give min level.
// - Debug-only range outside debug mode raises illegal instruction.
`timescale 1ns/1ps
`default_nettype none
`include "csrf_defines.svh"

module csrf_regfile #(
    parameter logic [31:0] VENDOR_CODE = 32'h00000000, // Arbitrary value
    parameter logic [31:0] ARCH_CODE = 32'h00000000, // Arbitrary value
    parameter logic [31:0] IMPL_CODE = 32'h00000000, // Arbitrary value
    parameter logic [31:0] HART_NUMBER = 32'h00000000,
    parameter logic [25:0] ISA_EXT_WMASK = 26'h0000000
) (
    input wire logic clock, // Core clock
    input wire logic rst_b, // Asynchronous reset
    input wire logic ce, // Clock enable, freezes all state
    input wire csrf_pkg::csrf_req_t req, // Access from pipeline
    input wire logic retire, // One instruction retired
    output csrf_pkg::csrf_rsp_t rsp // Answer, one cycle later
);
    import csrf_pkg::*;

    csrf_state_t st_ff;
    csrf_state_t nxt_st;
    logic hit;
    logic roNum;
    logic denied;
    logic doWrite;
    logic [31:0] rd;
    logic [31:0] w;

    // ------------------------------------------------------------
    // Field legalising helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] legalVector(input logic [31:0] v);
        // Vector mode 2 and 3 fold to direct mode
        legalVector = {v[31:2], v[1] ? 2'h0 : v[1:0]};
    endfunction

    function automatic logic [31:0] legalStatus(input logic [31:0] old,
            input logic [31:0] v, input logic [31:0] mask);
        logic [31:0] r;
        r = (old & ~mask) | (v & mask);
        // Previous-mode value 2 is unsupported, folds to user
        if (r[12:11] == 2'h2) begin
            r[12:11] = 2'h0;
        end
        legalStatus = r;
    endfunction

    function automatic logic [31:0] legalCfg(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        for (int i = 0; i < 4; i++) begin
            r[i*8 +: 8] = v[i*8 +: 8] & `CSRF_PCFG_MASK;
            // Write without read is reserved, drop the write permission
            if (r[i*8 + 1] && !r[i*8]) begin
                r[i*8 + 1] = 1'b0;
            end
        end
        legalCfg = r;
    endfunction

    // ------------------------------------------------------------
    // Access checks
    // ------------------------------------------------------------
    always_comb begin
        roNum = (req.addr[11:10] == 2'h3);
        denied = (req.priv < req.addr[9:8]);
        if ((req.addr >= `CSRF_DBG_FIRST) && (req.addr <= `CSRF_DBG_LAST) &&
                !req.debugMode) begin
            denied = 1'b1;
        end
        if (req.write && roNum) begin
            denied = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Decode, read mux, write update and counting
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        hit = 1'b0;
        rd = 32'h00000000;
        w = req.wdata;
        doWrite = req.valid && req.write && !denied;
        nxt_st.cycles = st_ff.cycles + 64'h1;
        if (retire) begin
            nxt_st.retired = st_ff.retired + 64'h1;
        end
        case (req.addr) inside
            `CSRF_SUP_STATUS: begin
                hit = 1'b1;
                rd = st_ff.status & `CSRF_SUP_STATUS_MASK;
                if (doWrite) begin
                    nxt_st.status = legalStatus(st_ff.status, w, `CSRF_SUP_STATUS_MASK);
                end
            end
            `CSRF_SUP_EXC_DELEG: begin
                hit = 1'b1;
                rd = st_ff.sExcDeleg;
                if (doWrite) nxt_st.sExcDeleg = w;
            end
            `CSRF_SUP_IRQ_DELEG: begin
                hit = 1'b1;
                rd = st_ff.sIrqDeleg;
                if (doWrite) nxt_st.sIrqDeleg = w;
            end
            `CSRF_SUP_IRQ_EN: begin
                hit = 1'b1;
                rd = st_ff.mIrqEn & `CSRF_SUP_IRQ_EN_MASK;
                if (doWrite) begin
                    nxt_st.mIrqEn = (st_ff.mIrqEn & ~`CSRF_SUP_IRQ_EN_MASK) |
                        (w & `CSRF_SUP_IRQ_EN_MASK);
                end
            end
            `CSRF_SUP_VECTOR: begin
                hit = 1'b1;
                rd = st_ff.sVector;
                if (doWrite) nxt_st.sVector = legalVector(w);
            end
            `CSRF_SUP_CNT_EN: begin
                hit = 1'b1;
                rd = st_ff.sCntEn;
                if (doWrite) nxt_st.sCntEn = w;
            end
            `CSRF_SUP_SCRATCH: begin
                hit = 1'b1;
                rd = st_ff.sScratch;
                if (doWrite) nxt_st.sScratch = w;
            end
            `CSRF_SUP_EXC_PC: begin
                hit = 1'b1;
                rd = st_ff.sExcPc;
                if (doWrite) nxt_st.sExcPc = {w[31:2], 2'h0};
            end
            `CSRF_SUP_CAUSE: begin
                hit = 1'b1;
                rd = {st_ff.sCauseIrq, 26'h0, st_ff.sCauseCode};
                if (doWrite) begin
                    nxt_st.sCauseIrq = w[31];
                    nxt_st.sCauseCode = w[4:0];
                end
            end
            `CSRF_SUP_TRAP_VAL: begin
                hit = 1'b1;
                rd = st_ff.sTrapVal;
                if (doWrite) nxt_st.sTrapVal = w;
            end
            `CSRF_SUP_IRQ_PEND: begin
                hit = 1'b1;
                rd = st_ff.mIrqPend & `CSRF_SUP_IRQ_PEND_MASK;
                if (doWrite) begin
                    nxt_st.mIrqPend = (st_ff.mIrqPend & ~`CSRF_SUP_IRQ_PEND_MASK) |
                        (w & `CSRF_SUP_IRQ_PEND_MASK);
                end
            end
            `CSRF_SUP_XLATE: begin
                hit = 1'b1;
                rd = st_ff.xlateCtl;
                // Only bare translation, a write selecting paging is dropped
                if (doWrite && !w[31]) nxt_st.xlateCtl = w;
            end
            `CSRF_MCH_STATUS: begin
                hit = 1'b1;
                rd = st_ff.status;
                if (doWrite) begin
                    nxt_st.status = legalStatus(st_ff.status, w, `CSRF_MCH_STATUS_MASK);
                end
            end
            `CSRF_MCH_ISA: begin
                hit = 1'b1;
                rd = {`CSRF_MXL_32, 4'h0, st_ff.isaExt};
                if (doWrite) begin
                    nxt_st.isaExt = (st_ff.isaExt & ~ISA_EXT_WMASK) |
                        (w[25:0] & ISA_EXT_WMASK);
                end
            end
            `CSRF_MCH_EXC_DELEG: begin
                hit = 1'b1;
                rd = st_ff.mExcDeleg;
                if (doWrite) nxt_st.mExcDeleg = w;
            end
            `CSRF_MCH_IRQ_DELEG: begin
                hit = 1'b1;
                rd = st_ff.mIrqDeleg;
                if (doWrite) nxt_st.mIrqDeleg = w;
            end
            `CSRF_MCH_IRQ_EN: begin
                hit = 1'b1;
                rd = st_ff.mIrqEn;
                if (doWrite) nxt_st.mIrqEn = w & `CSRF_MCH_IRQ_EN_MASK;
            end
            `CSRF_MCH_VECTOR: begin
                hit = 1'b1;
                rd = st_ff.mVector;
                if (doWrite) nxt_st.mVector = legalVector(w);
            end
            `CSRF_MCH_CNT_EN: begin
                hit = 1'b1;
                rd = st_ff.mCntEn;
                if (doWrite) nxt_st.mCntEn = w;
            end
            [`CSRF_EVT_FIRST:`CSRF_EVT_LAST]: begin
                hit = 1'b1;
                rd = st_ff.evtSel[req.addr[4:0]];
                if (doWrite) nxt_st.evtSel[req.addr[4:0]] = w;
            end
            `CSRF_MCH_SCRATCH: begin
                hit = 1'b1;
                rd = st_ff.mScratch;
                if (doWrite) nxt_st.mScratch = w;
            end
            `CSRF_MCH_EXC_PC: begin
                hit = 1'b1;
                rd = st_ff.mExcPc;
                if (doWrite) nxt_st.mExcPc = {w[31:2], 2'h0};
            end
            `CSRF_MCH_CAUSE: begin
                hit = 1'b1;
                rd = {st_ff.mCauseIrq, 26'h0, st_ff.mCauseCode};
                if (doWrite) begin
                    nxt_st.mCauseIrq = w[31];
                    nxt_st.mCauseCode = w[4:0];
                end
            end
            `CSRF_MCH_TRAP_VAL: begin
                hit = 1'b1;
                rd = st_ff.mTrapVal;
                if (doWrite) nxt_st.mTrapVal = w;
            end
            `CSRF_MCH_IRQ_PEND: begin
                hit = 1'b1;
                rd = st_ff.mIrqPend;
                if (doWrite) nxt_st.mIrqPend = w & `CSRF_MCH_IRQ_PEND_MASK;
            end
            [`CSRF_PCFG_FIRST:`CSRF_PCFG_LAST]: begin
                hit = 1'b1;
                rd = st_ff.pmpCfg[req.addr[1:0]];
                if (doWrite) nxt_st.pmpCfg[req.addr[1:0]] = legalCfg(w);
            end
            [`CSRF_PADDR_FIRST:`CSRF_PADDR_LAST]: begin
                hit = 1'b1;
                rd = st_ff.pmpAddr[req.addr[3:0]];
                if (doWrite) nxt_st.pmpAddr[req.addr[3:0]] = w;
            end
            `CSRF_TRIG_SEL: begin
                hit = 1'b1;
                // Single trigger, every selection reads back as trigger 0
                rd = 32'h00000000;
            end
            `CSRF_TRIG_DATA_A: begin
                hit = 1'b1;
                rd = st_ff.trigA;
                if (doWrite) nxt_st.trigA = w;
            end
            `CSRF_TRIG_DATA_B: begin
                hit = 1'b1;
                rd = st_ff.trigB;
                if (doWrite) nxt_st.trigB = w;
            end
            `CSRF_TRIG_DATA_C: begin
                hit = 1'b1;
                rd = st_ff.trigC;
                if (doWrite) nxt_st.trigC = w;
            end
            `CSRF_DBG_CTRL: begin
                hit = 1'b1;
                rd = st_ff.dbgCtl;
                if (doWrite) nxt_st.dbgCtl = w;
            end
            `CSRF_DBG_PC: begin
                hit = 1'b1;
                rd = st_ff.dbgPc;
                if (doWrite) nxt_st.dbgPc = w;
            end
            `CSRF_DBG_SCRATCH: begin
                hit = 1'b1;
                rd = st_ff.dbgScratch;
                if (doWrite) nxt_st.dbgScratch = w;
            end
            `CSRF_CYC_LO: begin
                hit = 1'b1;
                rd = st_ff.cycles[31:0];
                if (doWrite) nxt_st.cycles[31:0] = w;
            end
            `CSRF_CYC_HI: begin
                hit = 1'b1;
                rd = st_ff.cycles[63:32];
                if (doWrite) nxt_st.cycles[63:32] = w;
            end
            `CSRF_RET_LO: begin
                hit = 1'b1;
                rd = st_ff.retired[31:0];
                if (doWrite) nxt_st.retired[31:0] = w;
            end
            `CSRF_RET_HI: begin
                hit = 1'b1;
                rd = st_ff.retired[63:32];
                if (doWrite) nxt_st.retired[63:32] = w;
            end
            [`CSRF_HPM_FIRST:`CSRF_HPM_LAST]: begin
                hit = 1'b1;
                rd = st_ff.hpmLo[req.addr[4:0]];
                if (doWrite) nxt_st.hpmLo[req.addr[4:0]] = w;
            end
            [`CSRF_HPMH_FIRST:`CSRF_HPMH_LAST]: begin
                hit = 1'b1;
                rd = st_ff.hpmHi[req.addr[4:0]];
                if (doWrite) nxt_st.hpmHi[req.addr[4:0]] = w;
            end
            `CSRF_MVENDOR: begin
                hit = 1'b1;
                rd = VENDOR_CODE;
            end
            `CSRF_MARCH: begin
                hit = 1'b1;
                rd = ARCH_CODE;
            end
            `CSRF_MIMPL: begin
                hit = 1'b1;
                rd = IMPL_CODE;
            end
            `CSRF_MHART: begin
                hit = 1'b1;
                rd = HART_NUMBER;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // Unimplemented number: undo any access update, keep counting, and refuse
        if (!hit) begin
            nxt_st = st_ff;
            nxt_st.cycles = st_ff.cycles + 64'h1;
            nxt_st.retired = retire ? st_ff.retired + 64'h1 : st_ff.retired;
        end
        nxt_st.rsp.valid = req.valid;
        nxt_st.rsp.illegal = req.valid && (!hit || denied);
        nxt_st.rsp.rdata = (req.valid && hit && !denied) ? rd : 32'h00000000;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
            st_ff.isaExt <= `CSRF_ISA_EXT_RESET;
            st_ff.status[12:11] <= 2'h3;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign rsp = st_ff.rsp;
endmodule
`default_nettype wire

/* File: rtl/csrf_defines.svh */
// Register numbers, field masks and reset values of the register file
`ifndef CSRF_DEFINES_SVH
`define CSRF_DEFINES_SVH
`define CSRF_SUP_STATUS 12'h100
`define CSRF_SUP_EXC_DELEG 12'h102
`define CSRF_SUP_IRQ_DELEG 12'h103
`define CSRF_SUP_IRQ_EN 12'h104
`define CSRF_SUP_VECTOR 12'h105
`define CSRF_SUP_CNT_EN 12'h106
`define CSRF_SUP_SCRATCH 12'h140
`define CSRF_SUP_EXC_PC 12'h141
`define CSRF_SUP_CAUSE 12'h142
`define CSRF_SUP_TRAP_VAL 12'h143
`define CSRF_SUP_IRQ_PEND 12'h144
`define CSRF_SUP_XLATE 12'h180
`define CSRF_MCH_STATUS 12'h300
`define CSRF_MCH_ISA 12'h301
`define CSRF_MCH_EXC_DELEG 12'h302
`define CSRF_MCH_IRQ_DELEG 12'h303
`define CSRF_MCH_IRQ_EN 12'h304
`define CSRF_MCH_VECTOR 12'h305
`define CSRF_MCH_CNT_EN 12'h306
`define CSRF_EVT_FIRST 12'h323
`define CSRF_EVT_LAST 12'h33F
`define CSRF_MCH_SCRATCH 12'h340
`define CSRF_MCH_EXC_PC 12'h341
`define CSRF_MCH_CAUSE 12'h342
`define CSRF_MCH_TRAP_VAL 12'h343
`define CSRF_MCH_IRQ_PEND 12'h344
`define CSRF_PCFG_FIRST 12'h3A0
`define CSRF_PCFG_LAST 12'h3A3
`define CSRF_PADDR_FIRST 12'h3B0
`define CSRF_PADDR_LAST 12'h3BF
`define CSRF_TRIG_SEL 12'h7A0
`define CSRF_TRIG_DATA_A 12'h7A1
`define CSRF_TRIG_DATA_B 12'h7A2
`define CSRF_TRIG_DATA_C 12'h7A3
`define CSRF_DBG_FIRST 12'h7B0
`define CSRF_DBG_LAST 12'h7BF
`define CSRF_DBG_CTRL 12'h7B0
`define CSRF_DBG_PC 12'h7B1
`define CSRF_DBG_SCRATCH 12'h7B2
`define CSRF_CYC_LO 12'hB00
`define CSRF_RET_LO 12'hB02
`define CSRF_HPM_FIRST 12'hB03
`define CSRF_HPM_LAST 12'hB1F
`define CSRF_CYC_HI 12'hB80
`define CSRF_RET_HI 12'hB82
`define CSRF_HPMH_FIRST 12'hB83
`define CSRF_HPMH_LAST 12'hB9F
`define CSRF_MVENDOR 12'hF11
`define CSRF_MARCH 12'hF12
`define CSRF_MIMPL 12'hF13
`define CSRF_MHART 12'hF14
`define CSRF_MCH_STATUS_MASK 32'h0000198A
`define CSRF_SUP_STATUS_MASK 32'h00000122
`define CSRF_MCH_IRQ_EN_MASK 32'h00000AAA
`define CSRF_SUP_IRQ_EN_MASK 32'h00000222
`define CSRF_MCH_IRQ_PEND_MASK 32'h00000222
`define CSRF_SUP_IRQ_PEND_MASK 32'h00000002
`define CSRF_PCFG_MASK 8'h9F
`define CSRF_MXL_32 2'h1
`define CSRF_ISA_EXT_RESET 26'h0141100
`endif

/* File: rtl/csrf_pkg.sv */
// Types shared by the register file and its user
package csrf_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [1:0] priv;
        logic debugMode;
    } csrf_req_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [31:0] rdata;
    } csrf_rsp_t;

    typedef struct packed {
        csrf_rsp_t rsp;
        logic [31:0] status;
        logic [25:0] isaExt;
        logic [31:0] mExcDeleg, mIrqDeleg, mIrqEn, mVector, mCntEn;
        logic [31:0] mScratch, mExcPc, mTrapVal, mIrqPend;
        logic mCauseIrq;
        logic [4:0] mCauseCode;
        logic [31:0] sExcDeleg, sIrqDeleg, sVector, sCntEn;
        logic [31:0] sScratch, sExcPc, sTrapVal, xlateCtl;
        logic sCauseIrq;
        logic [4:0] sCauseCode;
        logic [3:0][31:0] pmpCfg;
        logic [15:0][31:0] pmpAddr;
        logic [31:3][31:0] evtSel;
        logic [63:0] cycles;
        logic [63:0] retired;
        logic [31:3][31:0] hpmLo;
        logic [31:3][31:0] hpmHi;
        logic [31:0] trigA, trigB, trigC;
        logic [31:0] dbgCtl, dbgPc, dbgScratch;
    } csrf_state_t;
endpackage

/* File: sim/csrf_regfile_monitor.sv */
// Port-level checks of the register file
`timescale 1ns/1ps
`default_nettype none
module csrf_regfile_monitor (
    input wire logic clock, // Core clock
    input wire logic rst_b, // Async reset
    input wire logic ce, // Clock enable
    input wire csrf_pkg::csrf_req_t req, // Access
    input wire logic retire, // Retire pulse
    input wire csrf_pkg::csrf_rsp_t rsp // Answer
);
    import csrf_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----
    // Request phases
    // ----
    sequence sTake;
        ce && req.valid;
    endsequence
    sequence sCycRead;
        sTake ##0 (!req.write && req.addr == 12'hB00 && req.priv == 2'h3);
    endsequence
    a_answer_next:
        assert property (sTake |=> rsp.valid) else $error("request not answered");
    a_no_extra:
        assert property (ce && !req.valid |=> !rsp.valid) else $error("answer without request");
    a_ro_write:
        assert property (sTake ##0 (req.write && req.addr[11:10] == 2'h3) |=> rsp.illegal)
            else $error("write to read-only number not refused");
    a_priv_low:
        assert property (sTake ##0 (req.priv < req.addr[9:8]) |=> rsp.illegal)
            else $error("low level access not refused");
    a_debug_only:
        assert property (sTake ##0 (req.addr[11:4] == 8'h7B && !req.debugMode) |=> rsp.illegal)
            else $error("debug register reached outside debug mode");
    a_illegal_zero:
        assert property (rsp.valid && rsp.illegal |-> rsp.rdata == 32'h0)
            else $error("refused access returned data");
    a_satp_open:
        assert property (sTake ##0 (req.addr == 12'h180 && req.priv != 2'h0) |=> !rsp.illegal)
            else $error("translation control refused");
    a_cause_no_trap:
        assert property (sTake ##0 (req.addr == 12'h342 && req.priv == 2'h3) |=> !rsp.illegal)
            else $error("cause access refused");
    a_cycle_step:
        assert property (sCycRead ##1 sCycRead |=> rsp.rdata == $past(rsp.rdata) + 32'h1)
            else $error("cycle counter did not step by one");
endmodule
bind csrf_regfile csrf_regfile_monitor mon (.clock(clock), .rst_b(rst_b), .ce(ce), .req(req),
    .retire(retire), .rsp(rsp));
`default_nettype wire

/* File: sim/csrf_pipe_model.sv */
// Pipeline model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module csrf_pipe_model (
    input wire logic clock, // Core clock
    input wire csrf_pkg::csrf_rsp_t rsp, // Answer
    output var csrf_pkg::csrf_req_t req // Access
);
    import csrf_pkg::*;
    initial req = '0;
    // Issue at a falling edge, answer read at the next falling edge
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] p, input logic dbg, output csrf_rsp_t r);
        req = '{valid: 1'h1, write: wr, addr: a, wdata: d, priv: p, debugMode: dbg};
        @(posedge clock);
        @(negedge clock);
        r = rsp;
    endtask
    task automatic idle(input int n);
        req.valid = 1'h0;
        repeat (n) @(negedge clock);
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the register file
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import csrf_pkg::*;
    logic clock;
    logic rst_b;
    logic ce;
    logic retire;
    csrf_req_t req;
    csrf_rsp_t rsp;
    csrf_rsp_t r;
    logic [31:0] first;
    int n_fail;
    int check_count;
    logic [11:0] lo [15] = '{12'h100, 12'h102, 12'h140, 12'h180, 12'h300, 12'h323, 12'h340,
        12'h3A0, 12'h3B0, 12'h7A0, 12'hB00, 12'hB02, 12'hB80, 12'hB82, 12'hF11};
    logic [11:0] hi [15] = '{12'h100, 12'h106, 12'h144, 12'h180, 12'h306, 12'h33F, 12'h344,
        12'h3A3, 12'h3BF, 12'h7A3, 12'hB00, 12'hB1F, 12'hB80, 12'hB9F, 12'hF14};
    logic [11:0] plain [8] = '{12'h140, 12'h143, 12'h340, 12'h343, 12'h3B0, 12'h3BF, 12'h323,
        12'h33F};

    csrf_regfile dut (.clock(clock), .rst_b(rst_b), .ce(ce), .req(req), .retire(retire),
        .rsp(rsp));
    csrf_pipe_model pipe (.clock(clock), .rsp(rsp), .req(req));

    always #5 clock = ~clock;

    // ----
    // Checking helpers
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] p, input logic dbg, input logic ill, input logic [31:0] exp);
        pipe.access(wr, a, d, p, dbg, r);
        check({30'h0, r.valid, r.illegal}, {30'h0, 1'h1, ill});
        if (!wr || ill) check(r.rdata, exp);
    endtask
    task automatic wm(input logic [11:0] a, input logic [31:0] d);
        acc(1'h1, a, d, 2'h3, 1'h0, 1'h0, 32'h0);
    endtask
    task automatic rm(input logic [11:0] a, input logic [31:0] exp);
        acc(1'h0, a, 32'h0, 2'h3, 1'h0, 1'h0, exp);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        clock = 1'h0;
        rst_b = 1'h0;
        ce = 1'h1;
        retire = 1'h0;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(negedge clock);
        rst_b = 1'h1;
        for (int i = 0; i < 15; i++) begin
            for (int a = lo[i]; a <= hi[i]; a++) begin
                pipe.access(1'h0, a[11:0], 32'h0, 2'h3, 1'h0, r);
                check({31'h0, r.illegal}, 32'h0);
            end
        end
        foreach (plain[i]) begin
            wm(plain[i], {20'hA5C3E, plain[i]});
            rm(plain[i], {20'hA5C3E, plain[i]});
        end
        $display("test decode done");
        rm(12'h301, 32'h40141100);
        rm(12'h300, 32'h00001800);
        wm(12'h301, 32'h3C000000);
        rm(12'h301, 32'h40141100);
        wm(12'h305, 32'h00001003);
        rm(12'h305, 32'h00001000);
        wm(12'h305, 32'h00001003);
        rm(12'h305, 32'h00001000);
        wm(12'h3A0, 32'hFFFFFFFF);
        rm(12'h3A0, 32'h9F9F9F9F);
        wm(12'h3A3, 32'h00000002);
        rm(12'h3A3, 32'h00000000);
        acc(1'h1, 12'h180, 32'h80000001, 2'h1, 1'h0, 1'h0, 32'h0);
        acc(1'h0, 12'h180, 32'h0, 2'h1, 1'h0, 1'h0, 32'h0);
        wm(12'h342, 32'h8000FFFF);
        rm(12'h342, 32'h8000001F);
        wm(12'h342, 32'h8000000B);
        rm(12'h342, 32'h8000000B);
        acc(1'h1, 12'h100, 32'hFFFFFFFF, 2'h1, 1'h0, 1'h0, 32'h0);
        acc(1'h0, 12'h100, 32'h0, 2'h1, 1'h0, 1'h0, 32'h00000122);
        acc(1'h1, 12'h100, 32'h00000120, 2'h1, 1'h0, 1'h0, 32'h0);
        acc(1'h0, 12'h100, 32'h0, 2'h1, 1'h0, 1'h0, 32'h00000120);
        $display("test fields done");
        acc(1'h0, 12'h101, 32'h0, 2'h3, 1'h0, 1'h1, 32'h0);
        acc(1'h0, 12'h107, 32'h0, 2'h3, 1'h0, 1'h1, 32'h0);
        acc(1'h1, 12'hF11, 32'h1, 2'h3, 1'h0, 1'h1, 32'h0);
        acc(1'h0, 12'h300, 32'h0, 2'h1, 1'h0, 1'h1, 32'h0);
        acc(1'h0, 12'h140, 32'h0, 2'h0, 1'h0, 1'h1, 32'h0);
        acc(1'h0, 12'h200, 32'h0, 2'h3, 1'h0, 1'h1, 32'h0);
        acc(1'h0, 12'h7B0, 32'h0, 2'h3, 1'h0, 1'h1, 32'h0);
        acc(1'h0, 12'h7B3, 32'h0, 2'h3, 1'h1, 1'h1, 32'h0);
        acc(1'h1, 12'h7B2, 32'h5A5A0F0F, 2'h3, 1'h1, 1'h0, 32'h0);
        acc(1'h0, 12'h7B2, 32'h0, 2'h3, 1'h1, 1'h0, 32'h5A5A0F0F);
        rm(12'hF11, 32'h0);
        $display("test refusals done");
        pipe.access(1'h0, 12'hB00, 32'h0, 2'h3, 1'h0, r);
        first = r.rdata;
        pipe.access(1'h0, 12'hB00, 32'h0, 2'h3, 1'h0, r);
        check(r.rdata, first + 32'h1);
        wm(12'hB80, 32'h00000005);
        wm(12'hB00, 32'hFFFFFFFE);
        rm(12'hB00, 32'hFFFFFFFE);
        rm(12'hB80, 32'h00000005);
        rm(12'hB80, 32'h00000006);
        wm(12'hB02, 32'h0);
        retire = 1'h1;
        pipe.idle(3);
        retire = 1'h0;
        rm(12'hB02, 32'h00000003);
        wm(12'hB00, 32'h00000010);
        ce = 1'h0;
        pipe.idle(5);
        ce = 1'h1;
        rm(12'hB00, 32'h00000010);
        $display("test counters done");
        close_out();
    end

    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
